// file: hdl/hbic_pkg.sv
// Package for the host-side controller of the flash disk bus interface
package hbic_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int SYS_ADDR_W = 16;
  // Strobe timing in ns, converted to 100 MHz cycles
  localparam int CLK_NS = 10;
  localparam int T_STROBE_NS = 70;
  localparam int T_AVD_NS = 20;
  localparam int T_RST_NS = 1000;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int AVD_CYC = (T_AVD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [1:0] BUS_W32 = 2'h2;
  localparam logic [1:0] BUS_W16 = 2'h1;

  typedef struct packed {
    logic write;
    logic mux_mode;
    logic [1:0] width;
    logic [SYS_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hbic_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic avd_n;
    logic rst_n;
  } hbic_ctl_s;
endpackage

// file: hdl/hbic_host.sv
// Host controller driving the flash disk device pins
`timescale 1ns/1ps
`default_nettype none
// Function
// - Address-valid falls after reset, before first read; the code drops it only at the start of each multiplexed access
// - First access waits until busy released
// - Each device selected by own identity
// - 32-bit host shifts address by one, device A0 held low
// - Interrupt trigger type matches device
// - Strobes from host read, write, select
// - Device reset from host power-on reset
module hbic_host (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire hbic_pkg::hbic_req_s req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [hbic_pkg::DATA_W-1:0] rsp_data_o,
  input wire logic cfg_16bit_i,
  input wire logic cfg_second_dev_i,
  input wire logic cfg_unlock_i,
  input wire logic cfg_irq_edge_i,
  output logic irq_o,
  output logic [hbic_pkg::ADDR_W-1:0] dev_addr_o,
  input wire logic [hbic_pkg::DATA_W-1:0] dev_data_i,
  output logic [hbic_pkg::DATA_W-1:0] dev_data_o,
  output logic dev_data_oe_o,
  output hbic_pkg::hbic_ctl_s dev_ctl_o,
  output logic dev_if_cfg_o,
  output logic dev_lock_n_o,
  output logic [1:0] dev_ident_o,
  input wire logic dev_busy_n_i,
  input wire logic dev_irq_n_i
);
  typedef enum {ST_RESET, ST_BUSY, ST_IDLE, ST_AVD, ST_STROBE, ST_DONE}
    hbic_state_e;
  hbic_state_e state_q;
  logic [hbic_pkg::CNT_W-1:0] cnt_q;
  logic busy_m_q, busy_s_q, irq_m_q, irq_s_q, irq_prev_q;
  hbic_pkg::hbic_req_s cur_q;
  logic [hbic_pkg::ADDR_W-1:0] eff_addr;
  logic [hbic_pkg::DATA_W-1:0] data_m_q, data_s_q;

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    busy_m_q <= dev_busy_n_i;
    busy_s_q <= busy_m_q;
    irq_m_q <= dev_irq_n_i;
    irq_s_q <= irq_m_q;
    data_m_q <= dev_data_i;
    data_s_q <= data_m_q;
  end

  // 32-bit host: device A0 low, A1 from system bit 2
  always_comb begin
    if (cur_q.width == hbic_pkg::BUS_W32) begin
      eff_addr = {cur_q.addr[hbic_pkg::ADDR_W:2], 1'b0};
    end else begin
      eff_addr = cur_q.addr[hbic_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_RESET;
      cnt_q <= '0;
      cur_q <= '0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == hbic_pkg::CNT_W'(hbic_pkg::RST_CYC)) begin
            state_q <= ST_BUSY;
            cnt_q <= '0;
          end
        end
        ST_BUSY: begin
          if (busy_s_q) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          cnt_q <= '0;
          if (req_valid_i) begin
            cur_q <= req_i;
            state_q <= req_i.mux_mode ? ST_AVD : ST_STROBE;
          end
        end
        ST_AVD: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == hbic_pkg::CNT_W'(hbic_pkg::AVD_CYC)) begin
            state_q <= ST_STROBE;
            cnt_q <= '0;
          end
        end
        ST_STROBE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == hbic_pkg::CNT_W'(hbic_pkg::STROBE_CYC)) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end

  // Pin drive, all from flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dev_ctl_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, avd_n: 1'b1,
                     rst_n: 1'b0};
      dev_addr_o <= '0;
      dev_data_o <= '0;
      dev_data_oe_o <= 1'b0;
    end else begin
      dev_ctl_o.rst_n <= (state_q != ST_RESET);
      dev_ctl_o.avd_n <= !(state_q == ST_AVD && cnt_q == '0);
      dev_ctl_o.ce_n <= !(state_q == ST_STROBE);
      dev_ctl_o.oe_n <= !(state_q == ST_STROBE && !cur_q.write);
      dev_ctl_o.we_n <= !(state_q == ST_STROBE && cur_q.write);
      dev_addr_o <= eff_addr;
      if (state_q == ST_AVD) begin
        dev_data_o <= hbic_pkg::DATA_W'(eff_addr);
        dev_data_oe_o <= 1'b1;
      end else if (state_q == ST_STROBE && cur_q.write) begin
        dev_data_o <= cur_q.wdata;
        dev_data_oe_o <= 1'b1;
      end else begin
        dev_data_oe_o <= 1'b0;
      end
    end
  end

  // Static straps and configuration
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dev_if_cfg_o <= 1'b0;
      dev_lock_n_o <= 1'b0;
      dev_ident_o <= 2'h0;
    end else begin
      dev_if_cfg_o <= cfg_16bit_i;
      dev_lock_n_o <= cfg_unlock_i;
      dev_ident_o <= {1'b0, cfg_second_dev_i};
    end
  end

  // Response capture; 8-bit mode upper lane forced to zero, pull-up ones dropped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
      req_ready_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_q == ST_STROBE) &&
        (cnt_q == hbic_pkg::CNT_W'(hbic_pkg::STROBE_CYC));
      // Strobe has stood long enough for the two-flop copy to hold it
      if (state_q == ST_STROBE && !cur_q.write &&
          cnt_q == hbic_pkg::CNT_W'(hbic_pkg::STROBE_CYC)) begin
        rsp_data_o <= cfg_16bit_i ? data_s_q :
          {8'h00, data_s_q[7:0]};
      end
      req_ready_o <= (state_q == ST_IDLE) && !req_valid_i;
    end
  end

  // Interrupt input: active low, level or falling edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_prev_q <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      irq_prev_q <= irq_s_q;
      irq_o <= cfg_irq_edge_i ? (irq_prev_q && !irq_s_q) : !irq_s_q;
    end
  end

  AST_NO_STROBE_BEFORE_READY: assert property (@(posedge clk_i)
    disable iff (srst_i) (state_q == ST_BUSY) |-> ##1 dev_ctl_o.ce_n)
    else $error("chip enable asserted while device busy");
  AST_STROBES_EXCLUSIVE: assert property (@(posedge clk_i)
    disable iff (srst_i) !(!dev_ctl_o.oe_n && !dev_ctl_o.we_n))
    else $error("read and write strobes together");
  AST_AVD_BEFORE_CE: assert property (@(posedge clk_i)
    disable iff (srst_i) $fell(dev_ctl_o.avd_n) |-> dev_ctl_o.ce_n)
    else $error("address valid fell during chip enable");
  AST_RESET_LOW_FIRST: assert property (@(posedge clk_i)
    disable iff (srst_i) (state_q == ST_RESET) |-> ##1 !dev_ctl_o.rst_n)
    else $error("device reset released too early");
  AST_IDENT_HIGH_LOW: assert property (@(posedge clk_i)
    disable iff (srst_i) !dev_ident_o[1])
    else $error("upper identity strap not low");
  AST_OE_WHEN_WRITE: assert property (@(posedge clk_i)
    disable iff (srst_i) !dev_ctl_o.we_n |-> dev_data_oe_o)
    else $error("data not driven during write");
  AST_NO_DRIVE_READ: assert property (@(posedge clk_i)
    disable iff (srst_i) !dev_ctl_o.oe_n |-> !dev_data_oe_o)
    else $error("host drives data during read");
  AST_RSP_AFTER_STROBE: assert property (@(posedge clk_i)
    disable iff (srst_i) rsp_valid_o |-> !$past(dev_ctl_o.ce_n))
    else $error("response without chip enable");
  AST_AVD_ADDR_DRIVEN: assert property (@(posedge clk_i)
    disable iff (srst_i) !dev_ctl_o.avd_n |-> dev_data_oe_o && dev_ctl_o.ce_n)
    else $error("address valid low without address on bus");
endmodule // hbic_host
`default_nettype wire

// file: testbench/hbic_dev_model.sv
// Behavioural model of the flash disk device at its host pins
`timescale 1ns/1ps
`default_nettype none
module hbic_dev_model #(
  parameter int BUSY_CYC = 20,
  parameter bit MY_ID = 1'h0,
  parameter bit SWAP = 1'h0
) (
  input wire logic clk_i,
  input wire logic [12:0] addr_i,
  input wire logic [15:0] data_i,
  input wire hbic_pkg::hbic_ctl_s ctl_i,
  input wire logic if_cfg_i,
  input wire logic [1:0] ident_i,
  input wire logic irq_req_i,
  input wire logic lock_n_i,
  output logic [15:0] data_o,
  output logic busy_n_o,
  output logic irq_n_o,
  output logic keys_ok_o
);
  logic [15:0] mem [0:4095];
  logic [12:0] mux_addr = 13'h0;
  logic mux_q = 1'h0;
  logic [15:0] pat = 16'h0;
  int cnt = 0;
  logic [12:0] a;
  logic [15:0] w;
  logic [15:0] ws;
  logic sel;
  // Software sticky lock is only set through registers, not modelled here
  logic sticky_lock_q = 1'h0;
  assign keys_ok_o = lock_n_i && !sticky_lock_q;
  assign a = mux_q ? mux_addr : addr_i;
  assign sel = ident_i[0] == MY_ID && !ident_i[1];
  assign w = mem[a[12:1]];
  assign ws = SWAP ? {w[7:0], w[15:8]} : w;
  assign irq_n_o = !irq_req_i;
  assign busy_n_o = ctl_i.rst_n && cnt == BUSY_CYC;
  always @(posedge clk_i) begin
    cnt <= !ctl_i.rst_n ? 0 : (cnt < BUSY_CYC ? cnt + 1 : cnt);
    pat <= pat + 16'h1357;
    if (!ctl_i.rst_n) mux_q <= 1'h0;
    else if (!ctl_i.avd_n) begin
      mux_q <= 1'h1;
      mux_addr <= data_i[12:0];
    end
    if (!ctl_i.we_n && !ctl_i.ce_n && sel) mem[a[12:1]] <= data_i;
  end
  // Released bus shows a moving pattern, never the last value
  always @* begin
    if (!ctl_i.ce_n && !ctl_i.oe_n && sel)
      data_o = if_cfg_i ? ws : {8'hFF, a[0] ? w[15:8] : w[7:0]};
    else data_o = pat;
  end
endmodule // hbic_dev_model
`default_nettype wire

// file: testbench/hbic_host_test.sv
// Self-checking testbench for the host bus controller
`timescale 1ns/1ps
`default_nettype none
module hbic_host_test;
  logic clk = 1'h0, srst = 1'h1, req_valid = 1'h0;
  logic cfg16 = 1'h1, second = 1'h0, keys_ok;
  logic unlock = 1'h0, edge_m = 1'h0, irq_req = 1'h0;
  hbic_pkg::hbic_req_s req = '0;
  hbic_pkg::hbic_ctl_s ctl;
  logic ready, rsp_valid, dev_oe, if_cfg, lock_n, busy_n, irq_n, irq;
  logic [15:0] rsp_data, dev_din, dev_dout, mdata;
  logic [12:0] dev_addr;
  logic [1:0] ident;
  int err_count = 0, checked = 0, cyc = 0, n;
  always #5 clk = ~clk;
  assign dev_din = dev_oe ? dev_dout : mdata;
  hbic_host dut_u (.clk_i(clk), .srst_i(srst), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .cfg_16bit_i(cfg16), .cfg_second_dev_i(second),
    .cfg_unlock_i(unlock), .cfg_irq_edge_i(edge_m), .irq_o(irq),
    .dev_addr_o(dev_addr), .dev_data_i(dev_din), .dev_data_o(dev_dout),
    .dev_data_oe_o(dev_oe), .dev_ctl_o(ctl), .dev_if_cfg_o(if_cfg),
    .dev_lock_n_o(lock_n), .dev_ident_o(ident), .dev_busy_n_i(busy_n),
    .dev_irq_n_i(irq_n));
  hbic_dev_model model_u (.clk_i(clk), .addr_i(dev_addr), .data_i(dev_din),
    .ctl_i(ctl), .if_cfg_i(if_cfg), .ident_i(ident), .irq_req_i(irq_req),
    .lock_n_i(lock_n), .data_o(mdata), .busy_n_o(busy_n), .irq_n_o(irq_n),
    .keys_ok_o(keys_ok));
  task automatic summarize;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer: wait for idle, offer the request for one edge, await answer
  task automatic access(input logic [3:0] kind, input logic [15:0] ad,
                        input logic [15:0] wd);
    int k;
    k = 0;
    while (ready !== 1'h1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    req <= {kind, ad, wd};
    req_valid <= 1'h1;
    @(posedge clk);
    req_valid <= 1'h0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp_valid !== 1'h1 && k < 100);
    check({15'h0, rsp_valid}, 16'h1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    check({15'h0, ctl.rst_n}, 16'h0);
    srst <= 1'h0;
    access(4'h9, 16'h0010, 16'hA55A);
    check({15'h0, busy_n}, 16'h1);
    access(4'h1, 16'h0010, 16'h0);
    check(rsp_data, 16'hA55A);
    access(4'h2, 16'h0020, 16'h0);
    check(rsp_data, 16'hA55A);
    cfg16 <= 1'h0;
    repeat (3) @(posedge clk);
    check({15'h0, if_cfg}, 16'h0);
    access(4'h0, 16'h0011, 16'h0);
    check(rsp_data, 16'h00A5);
    access(4'h0, 16'h0010, 16'h0);
    check(rsp_data, 16'h005A);
    cfg16 <= 1'h1;
    repeat (3) @(posedge clk);
    access(4'hD, 16'hE040, 16'h1234);
    access(4'h5, 16'h0040, 16'h0);
    check(rsp_data, 16'h1234);
    for (int v = 0; v < 2; v++) begin
      unlock <= v[0];
      repeat (3) @(posedge clk);
      check({15'h0, lock_n}, {15'h0, v[0]});
      check({15'h0, keys_ok}, {15'h0, v[0]});
    end
    irq_req <= 1'h1;
    repeat (5) @(posedge clk);
    check({15'h0, irq}, 16'h1);
    irq_req <= 1'h0;
    edge_m <= 1'h1;
    repeat (5) @(posedge clk);
    irq_req <= 1'h1;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += irq;
    end
    check(n[15:0], 16'h1);
    second <= 1'h1;
    repeat (3) @(posedge clk);
    check({14'h0, ident}, 16'h1);
    summarize();
  end
endmodule // hbic_host_test
`default_nettype wire
